// ===== hw/pwm_timer_params.svh
`ifndef PWM_TIMER_PARAMS_SVH
`define PWM_TIMER_PARAMS_SVH

// ****************************************************************
// Register byte offsets on the Wishbone bus.
// ****************************************************************
`define REG_IRQ_STATUS   8'h00
`define REG_TIMER_CTRL   8'h04
`define REG_COUNT        8'h08
`define REG_PRESCALE_LIM 8'h0C
`define REG_PRESCALE_CNT 8'h10
`define REG_MATCH_BASE   8'h18
`define REG_MATCH_ACT    8'h34
// The seventh action register sits at 8'h4C, so these start above it.
`define REG_EDGE_MODE    8'h50
`define REG_OUT_ENABLE   8'h54
`define REG_RELEASE      8'h58
`define REG_IRQ_MASK     8'h5C

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CTRL_RUN_BIT   0
`define CTRL_CLEAR_BIT 1
`define CTRL_PWM_BIT   3
`define ACT_IRQ_BIT    0
`define ACT_RESET_BIT  1
`define ACT_STOP_BIT   2
`define NUM_MATCH      7
`define NUM_OUT        6
`define ZERO_WORD      32'h0000_0000

`endif

// ===== hw/pwm_timer_pkg.sv
package pwm_timer_pkg;

  // Bus access phase of the register slave.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

  typedef logic [31:0] word_t;

endpackage

// ===== hw/pwm_prescaler.sv
`timescale 1ns/1ns
`include "pwm_timer_params.svh"

// Prescaler: counts clock cycles and emits a one-cycle tick at its limit.
module pwm_prescaler
  import pwm_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  // Control.
  input  wire logic  run_i,
  input  wire logic  clear_i,
  input  wire word_t limit_i,
  // Status.
  output word_t      count_o,
  output logic       tick_o
);

  word_t pre_r;  // Current prescale count.

  // The tick is combinational so the counter steps in the same edge.
  assign tick_o  = run_i && !clear_i && (pre_r == limit_i);  // see [RULE_18]
  assign count_o = pre_r;

  // Count cycles of the clock and wrap to zero at the limit.
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      pre_r <= `ZERO_WORD;
    end else if (tick_o) begin
      pre_r <= `ZERO_WORD;  // see [RULE_18]
    end else if (run_i) begin
      pre_r <= pre_r + 32'h0000_0001;  // see [RULE_17]
    end
  end

  chk_prescale_wrap: assert property (  // see [RULE_18]
    @(posedge clk_i) disable iff (rst_i)
    tick_o |=> pre_r == `ZERO_WORD)
    else $error("Prescaler did not wrap after tick.");

endmodule

// ===== hw/pwm_out_gen.sv
`timescale 1ns/1ns
`include "pwm_timer_params.svh"

// One output channel: single-edge or double-edge form.
module pwm_out_gen (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Configuration.
  input  wire logic enable_i,
  input  wire logic double_i,
  // Match events of the cycle start and of the two edge registers.
  input  wire logic start_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  // Output level.
  output logic      pwm_o
);

  // Single edge: high at cycle start, low at own match. A match in
  // the same count as the start leaves the output constantly low.
  // Double edge: set and clear places anywhere, either order.
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      pwm_o <= 1'b0;
    end else if (double_i) begin
      if (clr_i) begin
        pwm_o <= 1'b0;  // see [RULE_07]
      end else if (set_i) begin
        pwm_o <= 1'b1;  // see [RULE_08]
      end
    end else if (clr_i) begin
      pwm_o <= 1'b0;  // see [RULE_03]
    end else if (start_i) begin
      pwm_o <= 1'b1;  // see [RULE_05]
    end
  end

  chk_single_rise: assert property (  // see [RULE_05]
    @(posedge clk_i) disable iff (rst_i)
    enable_i && !double_i && start_i && !clr_i |=> pwm_o)
    else $error("Single-edge output missed its cycle-start rise.");

endmodule

// ===== hw/pwm_timer.sv
`timescale 1ns/1ns
`include "pwm_timer_params.svh"

// ****************************************************************
// Multi-channel PWM timer with Wishbone register slave.
// ****************************************************************

// Behaviour
// [RULE_01] Seven matches, six single or three double
// [RULE_02] Match zero resets counter, sets period
// [RULE_03] Own match sets single-edge falling position
// [RULE_04] Each single-edge output uses one match
// [RULE_05] Single-edge outputs rise at cycle start
// [RULE_06] Double-edge output uses two own matches
// [RULE_07] Separate matches set rise and fall
// [RULE_08] Order of edges gives pulse polarity
// [RULE_09] Both edges placeable anywhere in cycle
// [RULE_10] Period and width any whole count
// [RULE_11] Each match may raise an interrupt
// [RULE_12] Each match may stop or reset
// [RULE_13] Match updates take effect at cycle
// [RULE_14] Software releases new match values first
// [RULE_15] Without PWM mode acts as timer
// [RULE_16] 32-bit counter behind 32-bit prescaler
// [RULE_17] Counts cycles of the peripheral clock
// [RULE_18] Prescaler wraps and steps counter
// [RULE_19] Match sets flag, write one clears
module pwm_timer
  import pwm_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Outputs and interrupt.
  output logic      [5:0]  pwm_o,
  output logic             irq_o
);

  // ****************************************************************
  // State.
  // ****************************************************************
  bus_state_t  bus_r;                    // Bus phase.
  word_t       count_r;                  // Main counter.
  logic [3:0]  ctrl_r;                   // Run, clear, spare, PWM mode.
  word_t       limit_r;                  // Prescaler limit.
  word_t       shadow_r [`NUM_MATCH];    // Values software writes.
  word_t       active_r [`NUM_MATCH];    // Values in use.
  logic [2:0]  act_r    [`NUM_MATCH];    // Interrupt, reset, stop.
  logic [5:0]  dbl_r;                    // Double-edge select, chan 2..6.
  logic [5:0]  oen_r;                    // Output enables.
  logic [6:0]  rel_r;                    // Released, not yet loaded.
  logic [6:0]  stat_r;                   // Sticky match flags.
  logic [6:0]  mask_r;                   // Interrupt mask.
  logic [6:0]  hit;                      // Match in this cycle.
  logic [6:0]  hit_q;                    // Hit of the previous clock.
  logic        tick;                     // Prescaler step.
  word_t       pre_cnt;                  // Prescale count readback.
  logic        wr;                       // Write strobe.
  logic        stop_hit;                 // A match asks to stop.
  logic        reset_hit;                // A match asks to reset.
  logic        pwm_mode;                 // Cycle-synchronous mode.
  logic [31:0] wmask;                    // Byte-lane write mask.
  logic [31:0] rdata;                    // Read mux.

  assign pwm_mode = ctrl_r[`CTRL_PWM_BIT];
  // A write lands at the edge where the master sees ack high, so a
  // request that is dropped before its answer never changes a register.
  assign wr       = cyc_i && stb_i && we_i && bus_r == BUS_ACK;

  // Byte lanes come from sel_i.
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                  {8{sel_i[0]}}};

  // ****************************************************************
  // Prescaler.
  // ****************************************************************
  pwm_prescaler u_pre (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (ctrl_r[`CTRL_RUN_BIT]),
    .clear_i (ctrl_r[`CTRL_CLEAR_BIT]),
    .limit_i (limit_r),
    .count_o (pre_cnt),
    .tick_o  (tick)
  );  // see [RULE_16]

  // ****************************************************************
  // Match compare, one per match register.
  // ****************************************************************
  // Compare only on a counter step so a match fires once per count.
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_MATCH; gi++) begin : g_match
      assign hit[gi] = tick && (count_r == active_r[gi]);  // see [RULE_19]
    end
  endgenerate

  always_comb begin
    stop_hit  = 1'b0;
    reset_hit = 1'b0;
    for (int i = 0; i < `NUM_MATCH; i++) begin
      stop_hit  = stop_hit  | (hit[i] & act_r[i][`ACT_STOP_BIT]);
      reset_hit = reset_hit | (hit[i] & act_r[i][`ACT_RESET_BIT]);
    end
    // In PWM mode match zero always closes the cycle.
    reset_hit = reset_hit | (pwm_mode & hit[0]);  // see [RULE_02]
  end

  // ****************************************************************
  // Main counter.
  // ****************************************************************
  // Reset wins over count, and a reset match shortens the cycle to
  // the match value plus one, so any whole count period is possible.
  always_ff @(posedge clk_i) begin
    if (rst_i || ctrl_r[`CTRL_CLEAR_BIT]) begin
      count_r <= `ZERO_WORD;
    end else if (reset_hit) begin
      count_r <= `ZERO_WORD;  // see [RULE_10]
    end else if (tick) begin
      count_r <= count_r + 32'h0000_0001;  // see [RULE_16]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_q <= 7'h00;
    end else begin
      hit_q <= hit;
    end
  end

  // ****************************************************************
  // Shadow and active match values.
  // ****************************************************************
  // Outside PWM mode a written value is used at once; in PWM mode it
  // waits in the shadow until released and until match zero, so a
  // cycle never mixes old and new edges.
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `NUM_MATCH; i++) begin
      if (rst_i) begin
        shadow_r[i] <= `ZERO_WORD;
        active_r[i] <= `ZERO_WORD;
        act_r[i]    <= 3'b000;
      end else begin
        if (wr && adr_i == `REG_MATCH_BASE + 8'(4 * i)) begin
          shadow_r[i] <= (shadow_r[i] & ~wmask) | (dat_i & wmask);
          if (!pwm_mode) begin
            active_r[i] <= (shadow_r[i] & ~wmask) | (dat_i & wmask);
          end  // see [RULE_15]
        end else if (pwm_mode && hit[0] && rel_r[i]) begin
          active_r[i] <= shadow_r[i];  // see [RULE_13]
        end
        if (wr && adr_i == `REG_MATCH_ACT + 8'(4 * i) && sel_i[0]) begin
          act_r[i] <= dat_i[2:0];  // see [RULE_12]
        end
      end
    end
  end

  // Release latch: set by software, cleared when loaded.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_r <= 7'h00;
    end else if (wr && adr_i == `REG_RELEASE && sel_i[0]) begin
      rel_r <= rel_r | dat_i[6:0];  // see [RULE_14]
    end else if (pwm_mode && hit[0]) begin
      rel_r <= 7'h00;
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  // A stop match drops the run bit; software may set it again.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 4'h0;
      limit_r <= `ZERO_WORD;
      dbl_r  <= 6'h00;
      oen_r  <= 6'h00;
      mask_r <= 7'h00;
    end else begin
      if (stop_hit) begin
        ctrl_r[`CTRL_RUN_BIT] <= 1'b0;  // see [RULE_12]
      end else if (wr && adr_i == `REG_TIMER_CTRL && sel_i[0]) begin
        ctrl_r <= dat_i[3:0];
      end
      if (wr && adr_i == `REG_PRESCALE_LIM) begin
        limit_r <= (limit_r & ~wmask) | (dat_i & wmask);
      end
      if (wr && adr_i == `REG_EDGE_MODE && sel_i[0]) begin
        dbl_r <= dat_i[5:0];
      end
      if (wr && adr_i == `REG_OUT_ENABLE && sel_i[0]) begin
        oen_r <= dat_i[5:0];
      end
      if (wr && adr_i == `REG_IRQ_MASK && sel_i[0]) begin
        mask_r <= dat_i[6:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt flags.
  // ****************************************************************
  // A new match wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= 7'h00;
    end else begin
      stat_r <= (stat_r & ~((wr && adr_i == `REG_IRQ_STATUS && sel_i[0])
                 ? dat_i[6:0] : 7'h00))
                | (hit & {act_r[6][0], act_r[5][0], act_r[4][0],
                          act_r[3][0], act_r[2][0], act_r[1][0],
                          act_r[0][0]});  // see [RULE_11]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat_r & mask_r);
    end
  end

  // ****************************************************************
  // Output channels.
  // ****************************************************************
  // Channel n uses match n for single edge; for double edge it rises
  // on match n-1 and falls on match n. Channel 1 is single only.
  generate
    for (gi = 0; gi < `NUM_OUT; gi++) begin : g_out
      pwm_out_gen u_out (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .enable_i (oen_r[gi] && pwm_mode),
        .double_i (dbl_r[gi] && gi != 0),           // see [RULE_06]
        .start_i  (hit_q[0]),                        // see [RULE_04]
        .set_i    (hit_q[gi == 0 ? 0 : gi]),         // see [RULE_09]
        .clr_i    (hit_q[gi + 1]),                   // see [RULE_01]
        .pwm_o    (pwm_o[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Wishbone slave.
  // ****************************************************************
  always_comb begin
    rdata = `ZERO_WORD;
    case (adr_i)
      `REG_IRQ_STATUS:   rdata = {25'h0, stat_r};
      `REG_TIMER_CTRL:   rdata = {28'h0, ctrl_r};
      `REG_COUNT:        rdata = count_r;
      `REG_PRESCALE_LIM: rdata = limit_r;
      `REG_PRESCALE_CNT: rdata = pre_cnt;
      `REG_EDGE_MODE:    rdata = {26'h0, dbl_r};
      `REG_OUT_ENABLE:   rdata = {26'h0, oen_r};
      `REG_RELEASE:      rdata = {25'h0, rel_r};
      `REG_IRQ_MASK:     rdata = {25'h0, mask_r};
      default: begin
        for (int i = 0; i < `NUM_MATCH; i++) begin
          if (adr_i == `REG_MATCH_BASE + 8'(4 * i)) begin
            rdata = shadow_r[i];
          end
          if (adr_i == `REG_MATCH_ACT + 8'(4 * i)) begin
            rdata = {29'h0, act_r[i]};
          end
        end
      end
    endcase
  end

  // One answer per request after one wait state; ack drops after one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_r <= BUS_IDLE;
      ack_o <= 1'b0;
      dat_o <= `ZERO_WORD;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (cyc_i && stb_i) begin
            bus_r <= BUS_ACK;
            ack_o <= 1'b1;
            dat_o <= rdata;
          end
        end
        BUS_ACK: begin
          bus_r <= BUS_IDLE;
          ack_o <= 1'b0;
        end
        default: begin
          bus_r <= BUS_IDLE;
          ack_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  chk_period_reset: assert property (  // see [RULE_02]
    @(posedge clk_i) disable iff (rst_i)
    pwm_mode && hit[0] && !ctrl_r[`CTRL_CLEAR_BIT] |=> count_r == 0)
    else $error("Period match did not reset the counter.");

  chk_stop_match: assert property (  // see [RULE_12]
    @(posedge clk_i) disable iff (rst_i)
    stop_hit |=> !ctrl_r[`CTRL_RUN_BIT])
    else $error("Stop match left the timer running.");

  chk_flag_set: assert property (  // see [RULE_11]
    @(posedge clk_i) disable iff (rst_i)
    hit[1] && act_r[1][0] |=> stat_r[1])
    else $error("Interrupt flag not set on match.");

  chk_hold_unreleased: assert property (  // see [RULE_14]
    @(posedge clk_i) disable iff (rst_i)
    pwm_mode && !rel_r[3] && !wr |=> $stable(active_r[3]))
    else $error("Unreleased value took effect.");

  chk_count_step: assert property (  // see [RULE_16]
    @(posedge clk_i) disable iff (rst_i)
    tick && !reset_hit && !ctrl_r[`CTRL_CLEAR_BIT]
      |=> count_r == $past(count_r) + 1)
    else $error("Counter did not step on prescaler tick.");

  chk_irq_level: assert property (  // see [RULE_19]
    @(posedge clk_i) disable iff (rst_i)
    |(stat_r & mask_r) |=> irq_o)
    else $error("Unmasked flag did not raise interrupt.");

  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("Acknowledge held for more than one cycle.");

  chk_timer_load: assert property (  // see [RULE_15]
    @(posedge clk_i) disable iff (rst_i)
    !pwm_mode && wr && adr_i == `REG_MATCH_BASE + 8'h08 && sel_i == 4'hF
      |=> active_r[2] == $past(dat_i))
    else $error("Timer mode write not applied at once.");

  cov_period: cover property (@(posedge clk_i) pwm_mode && hit[0]);
  cov_reload: cover property (@(posedge clk_i) pwm_mode && hit[0] && |rel_r);
  cov_stop:   cover property (@(posedge clk_i) stop_hit);
  cov_irq:    cover property (@(posedge clk_i) irq_o);

endmodule

// ===== dv/pwm_load.sv
`timescale 1ns/1ns

// ****************************************************************
// Load on the output pins: counts high clocks and rising edges.
// ****************************************************************
module pwm_load (
  // Clock and window control.
  input  wire logic        clk_i,
  input  wire logic        clr_i,
  // Output pins under load.
  input  wire logic [5:0]  pwm_i,
  // Figures of the current window.
  output logic      [15:0] high_o [6],
  output logic      [15:0] rise_o [6]
);
  logic [5:0] last_r;  // Pin levels one clock earlier.

  // A clear restarts the window. The load only listens, so it can never
  // disturb the pins; a rise is counted against the previous sample.
  always_ff @(posedge clk_i) begin
    last_r <= pwm_i;
    for (int k = 0; k < 6; k++) begin
      if (clr_i) begin
        high_o[k] <= 16'h0000;
        rise_o[k] <= 16'h0000;
      end else begin
        high_o[k] <= high_o[k] + 16'(pwm_i[k]);
        rise_o[k] <= rise_o[k] + 16'(pwm_i[k] & ~last_r[k]);
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
`include "pwm_timer_params.svh"

// ****************************************************************
// Self-checking bench of the PWM timer.
// ****************************************************************
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
  end \
end

module tb_top
  import pwm_timer_pkg::*;
;
  logic        clk_i = 1'b0;  // Bench clock, 100 ns period.
  logic        rst_i = 1'b1;  // Synchronous reset.
  logic        cyc   = 1'b0;  // Bus cycle.
  logic        stb   = 1'b0;  // Bus strobe.
  logic        we    = 1'b0;  // Bus direction.
  logic [7:0]  adr   = 8'h00; // Bus address.
  word_t       dat   = 32'h0000_0000;
  word_t       dat_o;         // Read data.
  logic        ack_o;         // Bus acknowledge.
  logic [5:0]  pwm_o;         // Output pins.
  logic        irq_o;         // Interrupt level.
  logic        clr   = 1'b1;  // Restarts the load's window.
  logic [15:0] high [6];      // High clocks per pin.
  logic [15:0] rise [6];      // Rising edges per pin.
  word_t       rdata;         // Data of the last read.
  word_t       c1;            // First counter sample.
  int          num_errors = 0;
  int          n_compared = 0;
  integer      seed = 49;     // Fixed seed keeps runs repeatable.
  int unsigned p0;            // Period match value.
  int unsigned m [7];         // Match values in use.
  int unsigned v;             // Expected pulse width.

  always #50 clk_i = ~clk_i;

  pwm_timer i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .pwm_o(pwm_o), .irq_o(irq_o));

  pwm_load i_load (
    .clk_i(clk_i), .clr_i(clr), .pwm_i(pwm_o),
    .high_o(high), .rise_o(rise));

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic wb(input logic [7:0] a, input word_t d,
                    input logic w = 1'b1);
    int t;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t < 50) begin
      rdata = dat_o;
    end else begin
      num_errors++;
      end_sim();
    end
  endtask

  // Lets two periods settle, then counts over exactly three periods.
  task automatic measure();
    repeat (2 * (p0 + 1)) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (3 * (p0 + 1)) @(posedge clk_i);
    #1;
  endtask

  // Compares the load's figures of one pin.
  task automatic chk_ch(input int k, input int unsigned hi,
                        input int unsigned nr);
    `CHK("high clocks", hi, high[k])
    `CHK("rising edges", nr, rise[k])
  endtask

  // High clocks per period of a single-edge pin; a match on the period
  // value coincides with the cycle start, and low wins.
  function automatic int unsigned exp_hi(int unsigned mv, int unsigned pv);
    return (mv >= pv) ? 0 : mv + 1;
  endfunction

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // ****************************************************************
    // Reset values, unmapped place, counter behind the prescaler.
    // ****************************************************************
    wb(`REG_TIMER_CTRL, 32'h0000_0000, 1'b0);
    `CHK("ctrl reset", 32'h0000_0000, rdata)
    wb(8'h80, 32'hFFFF_FFFF);
    wb(8'h80, 32'h0000_0000, 1'b0);
    `CHK("unmapped", 32'h0000_0000, rdata)
    wb(`REG_PRESCALE_LIM, 32'hFFFF_FFFF);
    wb(`REG_PRESCALE_LIM, 32'h0000_0000, 1'b0);
    `CHK("prescale width", 32'hFFFF_FFFF, rdata)
    wb(`REG_PRESCALE_LIM, 32'h0000_0003);
    wb(`REG_TIMER_CTRL, 32'h0000_0001);
    wb(`REG_COUNT, 32'h0000_0000, 1'b0);
    c1 = rdata;
    // Two reads sixteen clocks apart: four prescaler wraps.
    repeat (13) @(posedge clk_i);
    wb(`REG_COUNT, 32'h0000_0000, 1'b0);
    `CHK("count step", c1 + 4, rdata)
    // ****************************************************************
    // Timer mode: stop with interrupt, mask, clear, reset on match.
    // ****************************************************************
    wb(`REG_PRESCALE_LIM, 32'h0000_0000);
    wb(`REG_TIMER_CTRL, 32'h0000_0002);
    wb(`REG_MATCH_BASE + 8'h08, 32'h0000_0009);
    wb(`REG_MATCH_ACT + 8'h08, 32'h0000_0005);
    wb(`REG_IRQ_MASK, 32'h0000_0004);
    wb(`REG_TIMER_CTRL, 32'h0000_0001);
    repeat (30) @(posedge clk_i);
    wb(`REG_TIMER_CTRL, 32'h0000_0000, 1'b0);
    `CHK("stop clears run", 32'h0000_0000, rdata)
    wb(`REG_COUNT, 32'h0000_0000, 1'b0);
    `CHK("stopped count", 1'b1, rdata inside {9, 10})
    wb(`REG_IRQ_STATUS, 32'h0000_0000, 1'b0);
    `CHK("match flag", 1'b1, rdata[2])
    `CHK("irq raised", 1'b1, irq_o)
    wb(`REG_IRQ_MASK, 32'h0000_0000);
    // The mask lands at the ack edge; the registered level follows.
    repeat (2) @(posedge clk_i);
    `CHK("irq masked", 1'b0, irq_o)
    wb(`REG_IRQ_MASK, 32'h0000_0004);
    wb(`REG_IRQ_STATUS, 32'h0000_0004);
    @(posedge clk_i);
    wb(`REG_IRQ_STATUS, 32'h0000_0000, 1'b0);
    `CHK("flag cleared", 1'b0, rdata[2])
    `CHK("irq cleared", 1'b0, irq_o)
    wb(`REG_MATCH_BASE + 8'h04, 32'h0000_0005);
    wb(`REG_MATCH_ACT + 8'h04, 32'h0000_0003);
    wb(`REG_TIMER_CTRL, 32'h0000_0002);
    wb(`REG_TIMER_CTRL, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    wb(`REG_COUNT, 32'h0000_0000, 1'b0);
    `CHK("reset on match", 1'b1, rdata <= 5)
    wb(`REG_MATCH_ACT + 8'h04, 32'h0000_0000);
    wb(`REG_MATCH_ACT + 8'h08, 32'h0000_0000);
    // ****************************************************************
    // PWM mode: six single-edge pins with random widths and corners.
    // ****************************************************************
    wb(`REG_TIMER_CTRL, 32'h0000_000A);
    p0 = 8 + ($unsigned($random(seed)) % 16);
    m[0] = p0;
    for (int n = 1; n < 7; n++) m[n] = $unsigned($random(seed)) % p0;
    m[1] = 0;
    m[6] = p0;
    for (int n = 0; n < 7; n++) wb(`REG_MATCH_BASE + 8'(4 * n), m[n]);
    wb(`REG_OUT_ENABLE, 32'h0000_003F);
    wb(`REG_RELEASE, 32'h0000_007F);
    wb(`REG_TIMER_CTRL, 32'h0000_0009);
    measure();
    for (int k = 0; k < 6; k++) begin
      v = exp_hi(m[k + 1], p0);
      chk_ch(k, 3 * v, (v > 0) ? 3 : 0);
    end
    // A new value waits for its release, then applies at a cycle start.
    wb(`REG_MATCH_BASE + 8'h04, 32'h0000_0003);
    wb(`REG_MATCH_BASE + 8'h04, 32'h0000_0000, 1'b0);
    `CHK("shadow read", 32'h0000_0003, rdata)
    measure();
    chk_ch(0, 3, 3);
    wb(`REG_RELEASE, 32'h0000_0002);
    measure();
    chk_ch(0, 12, 3);
    // ****************************************************************
    // Double-edge pin two: positive, then negative pulse.
    // ****************************************************************
    wb(`REG_EDGE_MODE, 32'h0000_0002);
    for (int c = 0; c < 2; c++) begin
      m[1] = c ? 6 : 2;
      m[2] = c ? 2 : 6;
      wb(`REG_MATCH_BASE + 8'h04, m[1]);
      wb(`REG_MATCH_BASE + 8'h08, m[2]);
      wb(`REG_RELEASE, 32'h0000_0006);
      measure();
      v = c ? p0 + 1 - 4 : 4;
      chk_ch(1, 3 * v, 3);
      chk_ch(0, 3 * exp_hi(m[1], p0), 3);
    end
    // Without PWM mode every pin rests low.
    wb(`REG_TIMER_CTRL, 32'h0000_0001);
    measure();
    for (int k = 0; k < 6; k++) chk_ch(k, 0, 0);
    // A reset in mid-run returns registers and pins to rest.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(`REG_OUT_ENABLE, 32'h0000_0000, 1'b0);
    `CHK("enable reset", 32'h0000_0000, rdata)
    `CHK("pins reset", 6'h00, pwm_o)
    `CHK("irq reset", 1'b0, irq_o)
    end_sim();
  end
endmodule
